// ===== rtcl_pkg.sv
package rtcl_pkg;
   // Register indices; the APB byte address is four times the index.
   localparam logic [5:0] CTRL_IDX_A = 6'h0F;
   localparam logic [5:0] CTRL_IDX_B = 6'h1F;
   localparam logic [5:0] FLAG_IDX = 6'h20;
   localparam logic [5:0] ISTAT_IDX = 6'h21;
   localparam logic [5:0] IMASK_IDX = 6'h22;
   // Flag register fields.
   localparam int COMP_STOP_BIT = 0;
   localparam int DATA_LOSS_BIT = 1;
   localparam logic [1:0] FLAG_RESET = 2'h3;
   // Control register fields.
   localparam int UPDATE_IRQ_EN_BIT = 5;
   localparam int COUNTDOWN_IRQ_EN_BIT = 4;
   localparam int ALARM_IRQ_EN_BIT = 3;
   localparam int EXT_EVENT_IRQ_EN_BIT = 2;
   localparam int CLOCK_STOP_BIT = 0;
   localparam logic [5:0] CTRL_WMASK = 6'h3D;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // Interrupt status and mask share the flag layout.
   localparam logic [1:0] ISTAT_RESET = 2'h0;
   localparam logic [1:0] IMASK_RESET = 2'h0;
   localparam int SYNC_STAGES = 2;
endpackage

// ===== rtcl_sync.sv
`timescale 1ns/100ps
module rtcl_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Checked at elaboration, so a bad width never reaches a build.
   if (WIDTH < 1) begin : g_bad_width
      $error("rtcl_sync: WIDTH must be at least 1");
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ===== rtcl_top.sv
`timescale 1ns/100ps
module rtcl_top (
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RESET,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic O_PREADY,
   output logic [31:0] O_PRDATA,
   output logic O_PSLVERR,
   // Supply comparators, asynchronous levels, high while below threshold
   input wire logic I_BELOW_FIRST_LOW_THRESHOLD,
   input wire logic I_BELOW_SECOND_LOW_THRESHOLD,
   // Flags and control towards the timekeeping logic
   output logic O_COMPENSATION_STOP_FLAG,
   output logic O_DATA_LOSS_FLAG,
   output logic O_UPDATE_IRQ_ENABLE,
   output logic O_COUNTDOWN_IRQ_ENABLE,
   output logic O_ALARM_IRQ_ENABLE,
   output logic O_EXT_EVENT_IRQ_ENABLE,
   output logic O_CLOCK_STOP,
   // Interrupt
   output logic O_IRQ
);
   logic [1:0] low_s;
   logic [1:0] flag_q;
   logic [1:0] flag_d;
   logic [5:0] ctrl_q;
   logic [5:0] ctrl_d;
   logic [1:0] istat_q;
   logic [1:0] istat_d;
   logic [1:0] imask_q;
   logic [1:0] imask_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic [5:0] idx;
   logic hit_ctrl;
   logic hit_flag;
   logic hit_istat;
   logic hit_imask;
   logic mapped;
   logic wr_acc;
   logic rd_setup;
   logic lane0;
   logic [1:0] flag_event;
   logic clr_comp;

   rtcl_sync #(
      .WIDTH(2)
   ) u_low_sync (
      .i_clk(I_CORE_CLK),
      .i_reset(I_RESET),
      .i_async({I_BELOW_SECOND_LOW_THRESHOLD, I_BELOW_FIRST_LOW_THRESHOLD}),
      .o_sync(low_s)
   );

   assign idx = I_PADDR[7:2];
   assign hit_ctrl = (idx == rtcl_pkg::CTRL_IDX_A) || (idx == rtcl_pkg::CTRL_IDX_B);
   assign hit_flag = (idx == rtcl_pkg::FLAG_IDX);
   assign hit_istat = (idx == rtcl_pkg::ISTAT_IDX);
   assign hit_imask = (idx == rtcl_pkg::IMASK_IDX);
   assign mapped = hit_ctrl | hit_flag | hit_istat | hit_imask;
   assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & mapped;
   assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   // All registers are eight bits or less, so only the low byte lane matters.
   assign lane0 = I_PSTRB[0];

   // Flags: the hardware set wins over a software clear in the same cycle.
   always_comb begin
      flag_d = flag_q;
      if (wr_acc && hit_flag && lane0) begin
         if (!I_PWDATA[rtcl_pkg::COMP_STOP_BIT]) begin
            flag_d = 2'h0;
         end
         if (!I_PWDATA[rtcl_pkg::DATA_LOSS_BIT]) begin
            flag_d[rtcl_pkg::DATA_LOSS_BIT] = 1'b0;
         end
      end
      if (low_s[0]) begin
         flag_d[rtcl_pkg::COMP_STOP_BIT] = 1'b1;
      end
      if (low_s[1]) begin
         flag_d[rtcl_pkg::DATA_LOSS_BIT] = 1'b1;
      end
   end

   assign flag_event = flag_d & ~flag_q;
   assign clr_comp = wr_acc && hit_flag && lane0 && !I_PWDATA[rtcl_pkg::COMP_STOP_BIT];

   // Control register; bit 1 and the reserved bits are not stored and read zero.
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_acc && hit_ctrl && lane0) begin
         ctrl_d = I_PWDATA[5:0] & rtcl_pkg::CTRL_WMASK;
      end
   end

   // Interrupt status is write-one-to-clear; a new event wins over the clear.
   always_comb begin
      istat_d = istat_q;
      imask_d = imask_q;
      if (wr_acc && hit_istat && lane0) begin
         istat_d = istat_q & ~I_PWDATA[1:0];
      end
      istat_d = istat_d | flag_event;
      if (wr_acc && hit_imask && lane0) begin
         imask_d = I_PWDATA[1:0];
      end
   end

   // Read data are captured in the setup cycle so they come from a flip-flop.
   always_comb begin
      prdata_d = prdata_q;
      if (rd_setup) begin
         prdata_d = 32'h0000_0000;
         if (hit_ctrl) begin
            prdata_d[5:0] = ctrl_q;
         end
         if (hit_flag) begin
            prdata_d[1:0] = flag_q;
         end
         if (hit_istat) begin
            prdata_d[1:0] = istat_q;
         end
         if (hit_imask) begin
            prdata_d[1:0] = imask_q;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         flag_q <= rtcl_pkg::FLAG_RESET;
         ctrl_q <= rtcl_pkg::CTRL_RESET;
         istat_q <= rtcl_pkg::ISTAT_RESET;
         imask_q <= rtcl_pkg::IMASK_RESET;
         prdata_q <= 32'h0000_0000;
      end else begin
         flag_q <= flag_d;
         ctrl_q <= ctrl_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
         prdata_q <= prdata_d;
      end
   end

   assign O_PREADY = 1'b1;
   assign O_PRDATA = prdata_q;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
   assign O_COMPENSATION_STOP_FLAG = flag_q[rtcl_pkg::COMP_STOP_BIT];
   assign O_DATA_LOSS_FLAG = flag_q[rtcl_pkg::DATA_LOSS_BIT];
   assign O_UPDATE_IRQ_ENABLE = ctrl_q[rtcl_pkg::UPDATE_IRQ_EN_BIT];
   assign O_COUNTDOWN_IRQ_ENABLE = ctrl_q[rtcl_pkg::COUNTDOWN_IRQ_EN_BIT];
   assign O_ALARM_IRQ_ENABLE = ctrl_q[rtcl_pkg::ALARM_IRQ_EN_BIT];
   assign O_EXT_EVENT_IRQ_ENABLE = ctrl_q[rtcl_pkg::EXT_EVENT_IRQ_EN_BIT];
   assign O_CLOCK_STOP = ctrl_q[rtcl_pkg::CLOCK_STOP_BIT];
   assign O_IRQ = |(istat_q & imask_q);

   property p_zero_clears;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (wr_acc && hit_flag && lane0 && !I_PWDATA[0] && low_s == 2'h0)
         |=> (O_COMPENSATION_STOP_FLAG == 1'b0) && (O_DATA_LOSS_FLAG == 1'b0);
   endproperty
   a_zero_clears: assert property (p_zero_clears)
      else $error("flag write of zero did not clear both flags");

   property p_read_flag;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (rd_setup && hit_flag) |=> (O_PRDATA[0] == $past(flag_q[0])) && (O_PRDATA[31:2] == '0);
   endproperty
   a_read_flag: assert property (p_read_flag)
      else $error("flag read data wrong");

   property p_sets_and_holds;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      low_s[0] |=> O_COMPENSATION_STOP_FLAG
         ##1 (O_COMPENSATION_STOP_FLAG || $past(clr_comp));
   endproperty
   a_sets_and_holds: assert property (p_sets_and_holds)
      else $error("compensation stop flag not set or not held");

   property p_write_one_keeps;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (wr_acc && hit_flag && I_PWDATA[0] && !low_s[0])
         |=> $stable(O_COMPENSATION_STOP_FLAG);
   endproperty
   a_write_one_keeps: assert property (p_write_one_keeps)
      else $error("writing one changed the compensation stop flag");

   property p_alias;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (wr_acc && idx == rtcl_pkg::CTRL_IDX_B && lane0)
         |=> ctrl_q == ($past(I_PWDATA[5:0]) & rtcl_pkg::CTRL_WMASK);
   endproperty
   a_alias: assert property (p_alias)
      else $error("control write at second address not taken");

   property p_ctrl_read;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (rd_setup && hit_ctrl) |=> (O_PRDATA[1] == 1'b0) && (O_PRDATA[31:6] == '0)
         && (O_PRDATA[5:2] == {O_UPDATE_IRQ_ENABLE, O_COUNTDOWN_IRQ_ENABLE,
                               O_ALARM_IRQ_ENABLE, O_EXT_EVENT_IRQ_ENABLE});
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control read layout wrong");

   property p_stop;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (wr_acc && hit_ctrl && lane0) |=> O_CLOCK_STOP == $past(I_PWDATA[0]);
   endproperty
   a_stop: assert property (p_stop)
      else $error("clock stop bit not written");

   property p_reset_ctrl;
      @(posedge I_CORE_CLK)
      $fell(I_RESET) |-> (ctrl_q == 6'h00) && !O_IRQ;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl)
      else $error("control register not zero after reset");

   property p_irq;
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (flag_event[0] && imask_q[0] && !(wr_acc && hit_imask)) |=> O_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked event did not raise interrupt");
endmodule

// ===== rtcl_top_tb.sv
`timescale 1ns/100ps
module rtcl_top_tb;
   logic clk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [3:0] strb;
   logic lo1;
   logic lo2;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic f_comp, f_loss, e_upd, e_cnt, e_alm, e_ext, c_stop, irq;
   logic [31:0] r;
   logic e;
   int miscompares = 0;
   int n_checks = 0;
   rtcl_top rtcl_top_i (.I_CORE_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
      .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
      .I_BELOW_FIRST_LOW_THRESHOLD(lo1), .I_BELOW_SECOND_LOW_THRESHOLD(lo2),
      .O_COMPENSATION_STOP_FLAG(f_comp), .O_DATA_LOSS_FLAG(f_loss),
      .O_UPDATE_IRQ_ENABLE(e_upd), .O_COUNTDOWN_IRQ_ENABLE(e_cnt),
      .O_ALARM_IRQ_ENABLE(e_alm), .O_EXT_EVENT_IRQ_ENABLE(e_ext),
      .O_CLOCK_STOP(c_stop), .O_IRQ(irq));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      pstrb <= w ? strb : 4'h0;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] x);
      xfer(1'b0, idx, 32'h0);
      chk(r, x);
      chk(e, 32'h0);
   endtask
   task automatic t_reset;
      chk({f_loss, f_comp, irq}, 32'h6);
      chk(pready, 32'h1);
      rd(rtcl_pkg::CTRL_IDX_A, 32'h0);
      chk({e_upd, e_cnt, e_alm, e_ext, c_stop}, 32'h0);
   endtask
   task automatic t_ctrl;
      xfer(1'b1, rtcl_pkg::CTRL_IDX_A, 32'h3F);
      rd(rtcl_pkg::CTRL_IDX_B, 32'h3D);
      chk({e_upd, e_cnt, e_alm, e_ext, c_stop}, 32'h1F);
      xfer(1'b1, rtcl_pkg::CTRL_IDX_B, 32'h21);
      rd(rtcl_pkg::CTRL_IDX_A, 32'h21);
      chk({e_upd, e_cnt, e_alm, e_ext, c_stop}, 32'h11);
      xfer(1'b1, rtcl_pkg::CTRL_IDX_A, 32'h0);
      @(posedge clk);
      chk(c_stop, 32'h0);
      // A write without the low byte lane must leave the register alone.
      strb = 4'hE;
      xfer(1'b1, rtcl_pkg::CTRL_IDX_A, 32'h3D);
      strb = 4'hF;
      rd(rtcl_pkg::CTRL_IDX_A, 32'h0);
   endtask
   task automatic t_flags;
      xfer(1'b1, rtcl_pkg::FLAG_IDX, 32'h0);
      rd(rtcl_pkg::FLAG_IDX, 32'h0);
      chk({f_loss, f_comp}, 32'h0);
      xfer(1'b1, rtcl_pkg::IMASK_IDX, 32'h1);
      @(posedge clk);
      lo1 <= 1'b1;
      repeat (5) @(posedge clk);
      chk({f_loss, f_comp}, 32'h1);
      rd(rtcl_pkg::ISTAT_IDX, 32'h1);
      chk(irq, 32'h1);
      lo1 <= 1'b0;
      xfer(1'b1, rtcl_pkg::FLAG_IDX, 32'h1);
      rd(rtcl_pkg::FLAG_IDX, 32'h1);
      xfer(1'b1, rtcl_pkg::FLAG_IDX, 32'h2);
      rd(rtcl_pkg::FLAG_IDX, 32'h0);
      xfer(1'b1, rtcl_pkg::ISTAT_IDX, 32'h1);
      @(posedge clk);
      chk(irq, 32'h0);
   endtask
   task automatic t_both;
      xfer(1'b1, rtcl_pkg::IMASK_IDX, 32'h0);
      lo1 <= 1'b1;
      lo2 <= 1'b1;
      repeat (5) @(posedge clk);
      lo1 <= 1'b0;
      lo2 <= 1'b0;
      rd(rtcl_pkg::FLAG_IDX, 32'h3);
      rd(rtcl_pkg::ISTAT_IDX, 32'h3);
      chk(irq, 32'h0);
      xfer(1'b1, rtcl_pkg::IMASK_IDX, 32'h2);
      @(posedge clk);
      chk(irq, 32'h1);
      xfer(1'b1, rtcl_pkg::FLAG_IDX, 32'h2);
      @(posedge clk);
      chk({f_loss, f_comp}, 32'h0);
      xfer(1'b1, rtcl_pkg::ISTAT_IDX, 32'h3);
      @(posedge clk);
      chk(irq, 32'h0);
      xfer(1'b0, 6'h3E, 32'h0);
      chk(e, 32'h1);
      chk(r, 32'h0);
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      strb = 4'hF;
      lo1 = 1'b0;
      lo2 = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_ctrl();
      t_flags();
      t_both();
      end_of_test();
   end
endmodule
